/* uart_pkg.sv */
// Functional notes
// - Receive FIFO always holds sixteen bytes
// - Transmitter starts as soon as a byte loads
// - Full transmit FIFO blocks writes until shift
// - Transmit interrupt while FIFO empty and enabled
// - First byte into empty FIFO clears interrupt
// - First byte delays next empty interrupt one character
// - Two bytes held cancels delay; next empty immediate
// - Receive level at trigger raises receive interrupt
// - Full receive FIFO refuses data, sets overrun
// - Idle four characters with data gives timeout
// - Read or new character clears timeout, restarts
// - Shared pin defaults to general-purpose input
// - Transmit function keeps pin tristate until powered
// - Powered UART drives pin; in GPIO mode the pin is driven only with output enable set and VCC_OK high
// - Share bit makes both IRQs follow either
// - Option register: enable, selector, polarity
// - Selected output shows polarity when buffer empty
// - Disabled or unselected outputs stay register-driven
// - Direction control only with FIFOs enabled
// - High-speed rates need divisor top bit set
package uart_pkg;
  localparam int NCH = 2;
  localparam int DEPTH = 16;
  localparam int CNT_W = 5;
  localparam int BIT_TICKS = 16;
  localparam int CHAR_BITS = 10;
  localparam int CHAR_TICKS = BIT_TICKS * CHAR_BITS;
  localparam int TOUT_CHARS = 4;
  localparam int TOUT_TICKS = TOUT_CHARS * CHAR_TICKS;
  localparam logic [CNT_W-1:0] FULL_CNT = 5'h10;
  localparam logic [CNT_W-1:0] TWO_CNT = 5'h02;
  localparam logic [7:0] DLY_LOAD = 8'(CHAR_TICKS);
  localparam logic [9:0] TOUT_LAST = 10'(TOUT_TICKS - 1);
  localparam logic [15:0] DIV_RST = 16'h0008;
  // Byte offsets
  localparam logic [7:0] CH_STRIDE = 8'h20;
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_IER = 8'h04;
  localparam logic [7:0] OFF_FCR = 8'h08;
  localparam logic [7:0] OFF_LSR = 8'h0c;
  localparam logic [7:0] OFF_DIV = 8'h10;
  localparam logic [7:0] OFF_MCR = 8'h14;
  localparam logic [7:0] OFF_OPT = 8'h18;
  localparam logic [7:0] OFF_CFG = 8'h40;
  localparam logic [7:0] OFF_PIN = 8'h44;
  // Field positions
  localparam int FCR_EN = 0;
  localparam int FCR_TRIG = 6;
  localparam int LSR_DR = 0;
  localparam int LSR_OVR = 1;
  localparam int LSR_THRE = 5;
  localparam int LSR_TEMT = 6;
  localparam int LSR_RXI = 8;
  localparam int LSR_TOI = 9;
  localparam int LSR_TXI = 10;
  localparam int OPT_EN = 0;
  localparam int OPT_RTS = 1;
  localparam int OPT_POL = 2;
  localparam int CFG_SHARE = 0;
  localparam int CFG_SEL0 = 4;
  localparam int CFG_SEL1 = 8;
  localparam int PIN_FUNC = 0;
  localparam int PIN_GOUT = 1;
  localparam int PIN_GOE = 2;
  localparam int PIN_PWR = 3;
  localparam int PIN_IN = 4;
  localparam int PIN_VCC = 5;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    R_DATA = 4'h0, R_IER = 4'h1, R_FCR = 4'h2, R_LSR = 4'h3,
    R_DIV = 4'h4, R_MCR = 4'h5, R_OPT = 4'h6, R_CFG = 4'h7,
    R_PIN = 4'h8, R_NONE = 4'hf
  } reg_e;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b10, TX_STOP = 2'b11
  } tx_e;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11
  } rx_e;
  typedef struct packed {
    logic ch;
    reg_e id;
  } dec_s;
  typedef struct packed {
    logic [1:0] ier;
    logic fifo_en;
    logic [1:0] trig;
    logic [15:0] div;
    logic [1:0] mcr;
    logic [2:0] opt;
    logic [3:0] irq_sel;
    logic [15:0] bcnt;
    tx_e tx_st;
    logic [3:0] tx_sub;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_line;
    rx_e rx_st;
    logic [3:0] rx_sub;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic ovr;
    logic tout;
    logic [9:0] tmr;
    logic [7:0] dly;
    logic multi;
    logic rts_n;
    logic dtr_n;
    logic irq;
  } ch_s;

  function automatic logic [CNT_W-1:0] trig_level(input logic [1:0] t);
    unique case (t)
      2'b00: trig_level = 5'h01;
      2'b01: trig_level = 5'h04;
      2'b10: trig_level = 5'h08;
      2'b11: trig_level = 5'h0e;
    endcase
  endfunction : trig_level

  function automatic dec_s addr_dec(input logic [7:0] a);
    logic [7:0] off;
    off = {3'b000, a[4:0]};
    addr_dec.ch = a[5];
    if (a == OFF_CFG) addr_dec.id = R_CFG;
    else if (a == OFF_PIN) addr_dec.id = R_PIN;
    else if (a >= (CH_STRIDE << 1)) addr_dec.id = R_NONE;
    else if (off == OFF_DATA) addr_dec.id = R_DATA;
    else if (off == OFF_IER) addr_dec.id = R_IER;
    else if (off == OFF_FCR) addr_dec.id = R_FCR;
    else if (off == OFF_LSR) addr_dec.id = R_LSR;
    else if (off == OFF_DIV) addr_dec.id = R_DIV;
    else if (off == OFF_MCR) addr_dec.id = R_MCR;
    else if (off == OFF_OPT) addr_dec.id = R_OPT;
    else addr_dec.id = R_NONE;
  endfunction : addr_dec
endpackage : uart_pkg

/* uart_fifo.sv */
`timescale 1ns/1ps
module uart_fifo import uart_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic push,
  input wire logic [7:0] din,
  // Drain side
  input wire logic pop,
  output logic [7:0] dout,
  // Level
  output logic [CNT_W-1:0] count,
  output logic full,
  output logic empty
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [3:0] rp;
    logic [3:0] wp;
    logic [CNT_W-1:0] cnt;
  } fifo_s;
  fifo_s s;
  fifo_s n;
  logic do_push;
  logic do_pop;

  assign full = s.cnt == FULL_CNT;
  assign empty = s.cnt == '0;
  assign dout = s.mem[s.rp];
  assign count = s.cnt;

  always_comb begin
    n = s;
    do_push = push && !full;
    do_pop = pop && !empty;
    if (do_push) begin
      n.mem[s.wp] = din;
      n.wp = s.wp + 4'h1;
    end
    if (do_pop) n.rp = s.rp + 4'h1;
    n.cnt = s.cnt + CNT_W'(do_push) - CNT_W'(do_pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) s <= '0;
    else s <= n;
  end

  property p_bounded;
    @(posedge clk) disable iff (!rst_n) s.cnt <= FULL_CNT;
  endproperty
  a_bounded: assert property (p_bounded)
    else $error("fifo level above sixteen");
  property p_full_block;
    @(posedge clk) disable iff (!rst_n)
      full && push && !pop |=> full && $stable(s.wp);
  endproperty
  a_full_block: assert property (p_full_block)
    else $error("write accepted into full fifo");
endmodule : uart_fifo

/* uart_fifo_autodirection.sv */
`timescale 1ns/1ps
module uart_fifo_autodirection import uart_pkg::*; (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // AXI4-Lite slave
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Serial lines
  input wire logic RX1,
  input wire logic RX2,
  output logic TX1,
  // Modem control, per port
  output logic [NCH-1:0] REQ_TO_SEND_N,
  output logic [NCH-1:0] TERM_READY_N,
  // Shared second-port pin
  input wire logic SHARED_GPIO_PIN_I,
  output logic SHARED_GPIO_PIN_O,
  output logic SHARED_GPIO_PIN_OE_N,
  input wire logic VCC_OK,
  // Interrupts
  output logic [NCH-1:0] UART_IRQ
);
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    ch_s [NCH-1:0] ch;
    logic aw_ok;
    logic [7:0] aw_addr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic share;
    logic pin_func;
    logic gpio_out;
    logic gpio_oe;
    logic uart2_pwr;
    logic pin_o;
    logic pin_oe_n;
  } top_s;

  logic [1:0] rst_q;
  logic rst_n;
  top_s s;
  top_s n;
  ch_s c;
  ch_s m;
  dec_s wdec;
  dec_s rdec;
  logic [15:0] rl;
  logic line;
  logic [NCH-1:0] tick, thre, chint, empty_all, rx_lvl, div_wr;
  logic [NCH-1:0] tx_push, tx_pop, rx_push, rx_pop;
  logic [NCH-1:0][7:0] rx_din, tx_dout, rx_dout;
  logic [NCH-1:0][CNT_W-1:0] tx_cnt, rx_cnt;
  logic port2_tx_out;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) rst_q <= 2'b00;
    else rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  for (genvar g = 0; g < NCH; g++) begin : g_fifo
    uart_fifo u_tx (
      .clk(CORE_CLK), .rst_n(rst_n), .push(tx_push[g]),
      .din(s.wdata[7:0]), .pop(tx_pop[g]), .dout(tx_dout[g]),
      .count(tx_cnt[g]), .full(), .empty()
    );
    uart_fifo u_rx (
      .clk(CORE_CLK), .rst_n(rst_n), .push(rx_push[g]),
      .din(rx_din[g]), .pop(rx_pop[g]), .dout(rx_dout[g]),
      .count(rx_cnt[g]), .full(), .empty()
    );
  end

  assign AWREADY = !s.aw_ok && !s.bvalid;
  assign WREADY = !s.w_ok && !s.bvalid;
  assign ARREADY = !s.rvalid;
  assign BVALID = s.bvalid;
  assign BRESP = s.bresp;
  assign RVALID = s.rvalid;
  assign RRESP = s.rresp;
  assign RDATA = s.rdata;
  assign port2_tx_out = s.ch[1].tx_line;
  assign TX1 = s.ch[0].tx_line;
  assign SHARED_GPIO_PIN_O = s.pin_o;
  assign SHARED_GPIO_PIN_OE_N = s.pin_oe_n;
  for (genvar g = 0; g < NCH; g++) begin : g_out
    assign REQ_TO_SEND_N[g] = s.ch[g].rts_n;
    assign TERM_READY_N[g] = s.ch[g].dtr_n;
    assign UART_IRQ[g] = s.ch[g].irq;
  end

  always_comb begin
    n = s;
    tx_push = '0;
    tx_pop = '0;
    rx_push = '0;
    rx_pop = '0;
    rx_din = '0;
    div_wr = '0;
    rl = '0;
    line = 1'b1;
    c = s.ch[0];
    m = s.ch[0];
    wdec = addr_dec(s.aw_addr);
    rdec = addr_dec(ARADDR);
    n.sync1 = {VCC_OK, SHARED_GPIO_PIN_I, RX2, RX1};
    n.sync2 = s.sync1;
    // Status seen by software and interrupt logic
    for (int i = 0; i < NCH; i++) begin
      tick[i] = s.ch[i].bcnt == '0;
      thre[i] = tx_cnt[i] == '0 && s.ch[i].dly == '0;
      empty_all[i] = tx_cnt[i] == '0 && s.ch[i].tx_st == TX_IDLE;
      rx_lvl[i] = rx_cnt[i] >= (s.ch[i].fifo_en ?
                  trig_level(s.ch[i].trig) : 5'h01);
      chint[i] = (s.ch[i].ier[0] && (rx_lvl[i] || s.ch[i].tout))
               || (s.ch[i].ier[1] && thre[i]);
    end
    // Write path: address and data in either order
    if (AWVALID && AWREADY) begin
      n.aw_ok = 1'b1;
      n.aw_addr = AWADDR;
    end
    if (WVALID && WREADY) begin
      n.w_ok = 1'b1;
      n.wdata = WDATA;
      n.wstrb = WSTRB;
    end
    if (s.bvalid && BREADY) n.bvalid = 1'b0;
    if (s.aw_ok && s.w_ok) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      unique case (wdec.id)
        // Full fifo drops the byte itself
        R_DATA: tx_push[wdec.ch] = s.wstrb[0];
        R_IER: if (s.wstrb[0]) n.ch[wdec.ch].ier = s.wdata[1:0];
        R_FCR: if (s.wstrb[0]) begin
          n.ch[wdec.ch].fifo_en = s.wdata[FCR_EN];
          n.ch[wdec.ch].trig = s.wdata[FCR_TRIG+:2];
        end
        R_LSR: ;
        R_DIV: begin
          if (s.wstrb[0]) n.ch[wdec.ch].div[7:0] = s.wdata[7:0];
          if (s.wstrb[1]) n.ch[wdec.ch].div[15:8] = s.wdata[15:8];
          div_wr[wdec.ch] = 1'b1;
        end
        R_MCR: if (s.wstrb[0]) n.ch[wdec.ch].mcr = s.wdata[1:0];
        R_OPT: if (s.wstrb[0]) n.ch[wdec.ch].opt = s.wdata[2:0];
        R_CFG: begin
          if (s.wstrb[0]) n.share = s.wdata[CFG_SHARE];
          if (s.wstrb[0]) n.ch[0].irq_sel = s.wdata[CFG_SEL0+:4];
          if (s.wstrb[1]) n.ch[1].irq_sel = s.wdata[CFG_SEL1+:4];
        end
        R_PIN: if (s.wstrb[0]) begin
          n.pin_func = s.wdata[PIN_FUNC];
          n.gpio_out = s.wdata[PIN_GOUT];
          n.gpio_oe = s.wdata[PIN_GOE];
          n.uart2_pwr = s.wdata[PIN_PWR];
        end
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    // Read path, one cycle after the address is taken
    if (s.rvalid && RREADY) n.rvalid = 1'b0;
    if (ARVALID && ARREADY) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = '0;
      unique case (rdec.id)
        R_DATA: begin
          n.rdata[7:0] = rx_dout[rdec.ch];
          rx_pop[rdec.ch] = rx_cnt[rdec.ch] != '0;
        end
        R_IER: n.rdata[1:0] = s.ch[rdec.ch].ier;
        R_FCR: begin
          n.rdata[FCR_EN] = s.ch[rdec.ch].fifo_en;
          n.rdata[FCR_TRIG+:2] = s.ch[rdec.ch].trig;
        end
        R_LSR: begin
          n.rdata[LSR_DR] = rx_cnt[rdec.ch] != '0;
          n.rdata[LSR_OVR] = s.ch[rdec.ch].ovr;
          n.rdata[LSR_THRE] = tx_cnt[rdec.ch] == '0;
          n.rdata[LSR_TEMT] = empty_all[rdec.ch];
          n.rdata[LSR_RXI] = rx_lvl[rdec.ch];
          n.rdata[LSR_TOI] = s.ch[rdec.ch].tout;
          n.rdata[LSR_TXI] = thre[rdec.ch];
          n.ch[rdec.ch].ovr = 1'b0;
        end
        R_DIV: n.rdata[15:0] = s.ch[rdec.ch].div;
        R_MCR: n.rdata[1:0] = s.ch[rdec.ch].mcr;
        R_OPT: n.rdata[2:0] = s.ch[rdec.ch].opt;
        R_CFG: begin
          n.rdata[CFG_SHARE] = s.share;
          n.rdata[CFG_SEL0+:4] = s.ch[0].irq_sel;
          n.rdata[CFG_SEL1+:4] = s.ch[1].irq_sel;
        end
        R_PIN: n.rdata[5:0] = {s.sync2[3], s.sync2[2], s.uart2_pwr,
                               s.gpio_oe, s.gpio_out, s.pin_func};
        default: n.rresp = RESP_SLVERR;
      endcase
    end
    // Per-channel engines
    for (int i = 0; i < NCH; i++) begin
      c = s.ch[i];
      m = n.ch[i];
      line = s.sync2[i];
      rl = c.div[15] ? {2'b00, c.div[14:1]} : c.div;
      if (div_wr[i]) m.bcnt = '0;
      else if (tick[i]) m.bcnt = (rl == '0) ? '0 : rl - 16'h0001;
      else m.bcnt = c.bcnt - 16'h0001;
      // Transmitter
      if (c.tx_st != TX_IDLE && tick[i]) m.tx_sub = c.tx_sub + 4'h1;
      unique case (c.tx_st)
        TX_IDLE: if (tx_cnt[i] != '0) begin
          tx_pop[i] = 1'b1;
          m.tx_sh = tx_dout[i];
          m.tx_st = TX_START;
          m.tx_sub = '0;
          m.tx_line = 1'b0;
        end
        TX_START: if (tick[i] && c.tx_sub == 4'hf) begin
          m.tx_st = TX_DATA;
          m.tx_bit = '0;
          m.tx_line = c.tx_sh[0];
        end
        TX_DATA: if (tick[i] && c.tx_sub == 4'hf) begin
          if (c.tx_bit == 3'h7) begin
            m.tx_st = TX_STOP;
            m.tx_line = 1'b1;
          end else begin
            m.tx_bit = c.tx_bit + 3'h1;
            m.tx_sh = c.tx_sh >> 1;
            m.tx_line = c.tx_sh[1];
          end
        end
        TX_STOP: if (tick[i] && c.tx_sub == 4'hf) m.tx_st = TX_IDLE;
      endcase
      // Receiver, 16x oversampled
      if (c.rx_st != RX_IDLE && tick[i]) m.rx_sub = c.rx_sub + 4'h1;
      unique case (c.rx_st)
        RX_IDLE: if (!line) begin
          m.rx_st = RX_START;
          m.rx_sub = '0;
        end
        RX_START: if (tick[i] && c.rx_sub == 4'h7) begin
          m.rx_st = line ? RX_IDLE : RX_DATA;
          m.rx_sub = '0;
          m.rx_bit = '0;
        end
        RX_DATA: if (tick[i] && c.rx_sub == 4'hf) begin
          m.rx_sh = {line, c.rx_sh[7:1]};
          if (c.rx_bit == 3'h7) m.rx_st = RX_STOP;
          else m.rx_bit = c.rx_bit + 3'h1;
        end
        RX_STOP: if (tick[i] && c.rx_sub == 4'hf) begin
          m.rx_st = RX_IDLE;
          if (rx_cnt[i] == FULL_CNT) m.ovr = 1'b1;
          else begin
            rx_push[i] = 1'b1;
            rx_din[i] = c.rx_sh;
          end
        end
      endcase
      // Receive timeout
      if (rx_push[i] || rx_pop[i] || rx_cnt[i] == '0 || !c.fifo_en) begin
        m.tmr = '0;
        m.tout = 1'b0;
      end else if (tick[i] && !c.tout) begin
        if (c.tmr == TOUT_LAST) m.tout = 1'b1;
        else m.tmr = c.tmr + 10'h001;
      end
      // Transmit-empty holdoff
      if (thre[i]) m.multi = 1'b0;
      if (tx_cnt[i] >= TWO_CNT) begin
        m.multi = 1'b1;
        m.dly = '0;
      end else if (tx_push[i] && tx_cnt[i] == '0 && !c.multi) begin
        m.dly = DLY_LOAD;
      end else if (c.dly != '0 && tick[i]) begin
        m.dly = c.dly - 8'h01;
      end
      // Direction control on modem outputs
      m.rts_n = (c.opt[OPT_EN] && c.fifo_en && c.opt[OPT_RTS])
              ? (empty_all[i] ? c.opt[OPT_POL] : !c.opt[OPT_POL])
              : !c.mcr[1];
      m.dtr_n = (c.opt[OPT_EN] && c.fifo_en && !c.opt[OPT_RTS])
              ? (empty_all[i] ? c.opt[OPT_POL] : !c.opt[OPT_POL])
              : !c.mcr[0];
      m.irq = c.irq_sel != '0
              && (chint[i] || (s.share && chint[NCH-1-i]));
      n.ch[i] = m;
    end
    // Shared pin
    if (s.pin_func) begin
      n.pin_oe_n = !s.uart2_pwr;
      n.pin_o = port2_tx_out;
    end else begin
      n.pin_oe_n = !(s.sync2[3] && s.gpio_oe);
      n.pin_o = s.gpio_out;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      // Serial inputs idle high, no false start
      s.sync1 <= 4'h3;
      s.sync2 <= 4'h3;
      for (int i = 0; i < NCH; i++) begin
        s.ch[i].div <= DIV_RST;
        s.ch[i].tx_line <= 1'b1;
        s.ch[i].rts_n <= 1'b1;
        s.ch[i].dtr_n <= 1'b1;
      end
      s.pin_oe_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!rst_n);

  property p_tx_start;
    s.ch[0].tx_st == TX_IDLE && tx_cnt[0] != '0
      |=> s.ch[0].tx_st == TX_START && !TX1;
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("transmitter did not start on loaded byte");
  property p_thre_clear;
    tx_push[0] && tx_cnt[0] == '0 |=> !thre[0];
  endproperty
  a_thre_clear: assert property (p_thre_clear)
    else $error("empty indication stayed after first write");
  property p_holdoff;
    tx_push[0] && tx_cnt[0] == '0 && !s.ch[0].multi
      |=> s.ch[0].dly == DLY_LOAD;
  endproperty
  a_holdoff: assert property (p_holdoff)
    else $error("one character holdoff not loaded");
  property p_immediate;
    s.ch[0].multi && tx_cnt[0] == 5'h01 && tx_pop[0] && !tx_push[0]
      |=> thre[0];
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("empty indication delayed after two bytes");
  property p_rx_irq;
    s.ch[0].irq_sel != '0 && s.ch[0].ier[0] && rx_lvl[0]
      |=> UART_IRQ[0];
  endproperty
  a_rx_irq: assert property (p_rx_irq)
    else $error("receive level did not interrupt");
  property p_overrun;
    s.ch[0].rx_st == RX_STOP && tick[0] && s.ch[0].rx_sub == 4'hf
      && rx_cnt[0] == FULL_CNT |=> s.ch[0].ovr && rx_cnt[0] == FULL_CNT;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");
  property p_tout_set;
    $rose(s.ch[0].tout) |-> $past(s.ch[0].tmr) == TOUT_LAST
      && rx_cnt[0] != '0;
  endproperty
  a_tout_set: assert property (p_tout_set)
    else $error("timeout raised early");
  property p_tout_clear;
    rx_pop[0] |=> !s.ch[0].tout && s.ch[0].tmr == '0;
  endproperty
  a_tout_clear: assert property (p_tout_clear)
    else $error("timeout not cleared by read");
  property p_pin_tri;
    s.pin_func && !s.uart2_pwr |=> SHARED_GPIO_PIN_OE_N;
  endproperty
  a_pin_tri: assert property (p_pin_tri)
    else $error("shared pin driven while unpowered");
  property p_share;
    s.share && s.ch[1].irq_sel != '0 && chint[0] |=> UART_IRQ[1];
  endproperty
  a_share: assert property (p_share)
    else $error("shared interrupt not mirrored");
  property p_dir;
    s.ch[0].opt[OPT_EN] && s.ch[0].opt[OPT_RTS] && s.ch[0].fifo_en
      && empty_all[0] |=> REQ_TO_SEND_N[0] == $past(s.ch[0].opt[OPT_POL]);
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction output wrong when empty");
  property p_dir_off;
    !(s.ch[0].opt[OPT_EN] && s.ch[0].fifo_en)
      |=> REQ_TO_SEND_N[0] == !$past(s.ch[0].mcr[1]);
  endproperty
  a_dir_off: assert property (p_dir_off)
    else $error("request output not register driven");

  c_tx_start: cover property (p_tx_start);
  c_tout: cover property ($rose(s.ch[0].tout));
  c_overrun: cover property ($rose(s.ch[0].ovr));
  c_share: cover property (s.share && UART_IRQ[0] && UART_IRQ[1]);
endmodule : uart_fifo_autodirection

/* serial_peer.sv */
`timescale 1ns/1ps
module serial_peer (
  // Clock
  input wire logic clk,
  // Serial lines
  input wire logic tx_line,
  output logic rx_line,
  // Received tally
  output int rx_count,
  output logic [7:0] last_byte
);
  initial begin
    rx_line = 1'h1;
    rx_count = 0;
    last_byte = 8'h00;
  end
  // One 8N1 character, 16 clocks a bit
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      rx_line <= f[i];
      repeat (16) @(posedge clk);
    end
  endtask : send
  // Mid-bit sampling from each start edge
  always begin
    @(negedge tx_line);
    repeat (24) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      last_byte[i] = tx_line;
      repeat (16) @(posedge clk);
    end
    rx_count++;
  end
endmodule : serial_peer

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top import uart_pkg::*;;
  logic CORE_CLK = 1'h0;
  logic RST_N = 1'h0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic AWVALID = 1'h0, WVALID = 1'h0, ARVALID = 1'h0;
  logic BREADY = 1'h0, RREADY = 1'h0, VCC_OK = 1'h1;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, RX1, TX1;
  logic SHARED_GPIO_PIN_O, SHARED_GPIO_PIN_OE_N;
  logic [1:0] BRESP, RRESP, REQ_TO_SEND_N, TERM_READY_N, UART_IRQ, resp;
  logic [31:0] RDATA, rd;
  int errors = 0;
  int checked = 0;
  int n;
  always #25 CORE_CLK = ~CORE_CLK;
  uart_fifo_autodirection uart_fifo_autodirection_i (.CORE_CLK, .RST_N,
    .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB(4'hf), .WVALID, .WREADY,
    .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP,
    .RVALID, .RREADY, .RX1, .RX2(1'h1), .TX1, .REQ_TO_SEND_N, .TERM_READY_N,
    .SHARED_GPIO_PIN_I(1'h0), .SHARED_GPIO_PIN_O, .SHARED_GPIO_PIN_OE_N,
    .VCC_OK, .UART_IRQ);
  serial_peer peer_i (.clk(CORE_CLK), .tx_line(TX1), .rx_line(RX1),
    .rx_count(), .last_byte());
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'h1;
    WVALID <= 1'h1;
    BREADY <= 1'h1;
    b = 1'h0;
    while (b !== 1'h1) begin
      @(negedge CORE_CLK);
      aw = AWVALID & AWREADY;
      w = WVALID & WREADY;
      b = BVALID;
      @(posedge CORE_CLK);
      if (aw === 1'h1) AWVALID <= 1'h0;
      if (w === 1'h1) WVALID <= 1'h0;
    end
    BREADY <= 1'h0;
    @(posedge CORE_CLK);
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    logic ar, r;
    ARADDR <= a;
    ARVALID <= 1'h1;
    RREADY <= 1'h1;
    r = 1'h0;
    while (r !== 1'h1) begin
      @(negedge CORE_CLK);
      ar = ARVALID & ARREADY;
      r = RVALID;
      rd = RDATA;
      resp = RRESP;
      @(posedge CORE_CLK);
      if (ar === 1'h1) ARVALID <= 1'h0;
    end
    RREADY <= 1'h0;
    @(posedge CORE_CLK);
  endtask : rd_reg
  task automatic wait_clk(input int k);
    repeat (k) @(posedge CORE_CLK);
  endtask : wait_clk
  task automatic print_verdict;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  initial begin
    wait_clk(15000);
    errors++;
    print_verdict;
  end
  initial begin
    wait_clk(8);
    RST_N <= 1'h1;
    wait_clk(3);
    chk("pin oe_n", 32'h1, 32'(SHARED_GPIO_PIN_OE_N));
    rd_reg(OFF_DIV);
    chk("div", {16'h0, DIV_RST}, rd);
    rd_reg(8'h3c);
    chk("unmapped", 32'(RESP_SLVERR), 32'(resp));
    wr(OFF_PIN, 32'h1);
    chk("pin oe_n unpowered", 32'h1, 32'(SHARED_GPIO_PIN_OE_N));
    wr(OFF_PIN, 32'h9);
    wait_clk(4);
    chk("pin oe_n powered", 32'h0, 32'(SHARED_GPIO_PIN_OE_N));
    chk("pin tx idle", 32'h1, 32'(SHARED_GPIO_PIN_O));
    wr(OFF_PIN, 32'h6);
    wait_clk(4);
    chk("pin gpio oe_n", 32'h0, 32'(SHARED_GPIO_PIN_OE_N));
    chk("pin gpio out", 32'h1, 32'(SHARED_GPIO_PIN_O));
    VCC_OK <= 1'h0;
    wait_clk(5);
    chk("pin oe_n no vcc", 32'h1, 32'(SHARED_GPIO_PIN_OE_N));
    VCC_OK <= 1'h1;
    wr(OFF_DIV, 32'h1);
    wr(OFF_OPT, 32'h7);
    wr(OFF_MCR, 32'h1);
    wr(OFF_CFG, 32'h10);
    wr(OFF_CFG, 32'h11);
    wr(OFF_IER, 32'h3);
    wr(OFF_FCR, 32'h41);
    chk("irq one", 32'h1, 32'(UART_IRQ));
    wr(OFF_CFG, 32'h211);
    chk("irq empty", 32'h3, 32'(UART_IRQ));
    chk("dtr", 32'h2, 32'(TERM_READY_N));
    chk("rts empty", 32'h3, 32'(REQ_TO_SEND_N));
    for (int i = 1; i <= 18; i++) begin
      wr(OFF_DATA, 32'(i));
      if (i == 1) chk("irq load", 32'h0, 32'(UART_IRQ));
    end
    chk("rts busy", 32'h2, 32'(REQ_TO_SEND_N));
    for (n = 0; n < 4000 && peer_i.rx_count < 17; n++) wait_clk(1);
    chk("irq drained", 32'h3, 32'(UART_IRQ));
    wait_clk(200);
    chk("tx count", 32'd17, 32'(peer_i.rx_count));
    chk("tx last", 32'h11, 32'(peer_i.last_byte));
    chk("rts drained", 32'h3, 32'(REQ_TO_SEND_N));
    wr(OFF_DATA, 32'ha5);
    wait_clk(100);
    chk("irq holdoff", 32'h0, 32'(UART_IRQ));
    wait_clk(300);
    chk("irq after", 32'h3, 32'(UART_IRQ));
    chk("tx byte", 32'ha5, 32'(peer_i.last_byte));
    for (int i = 0; i < 17; i++) begin
      peer_i.send(8'(8'h30 + i));
      if (i == 2 || i == 3) begin
        rd_reg(OFF_LSR);
        chk("rx level", 32'(i == 3), 32'(rd[LSR_RXI]));
      end
    end
    wait_clk(4);
    rd_reg(OFF_LSR);
    chk("overrun", 32'h1, 32'(rd[LSR_OVR]));
    for (int i = 0; i < 16; i++) begin
      rd_reg(OFF_DATA);
      chk("rx byte", 32'(8'h30 + i), {24'h0, rd[7:0]});
    end
    wr(OFF_FCR, 32'hc1);
    peer_i.send(8'h77);
    peer_i.send(8'h78);
    wait_clk(300);
    rd_reg(OFF_LSR);
    chk("timeout early", 32'h0, 32'(rd[LSR_TOI]));
    wait_clk(450);
    rd_reg(OFF_LSR);
    chk("timeout", 32'h1, 32'(rd[LSR_TOI]));
    rd_reg(OFF_DATA);
    chk("rx byte", 32'h77, {24'h0, rd[7:0]});
    rd_reg(OFF_LSR);
    chk("timeout clear", 32'h0, 32'(rd[LSR_TOI]));
    wait_clk(750);
    rd_reg(OFF_LSR);
    chk("timeout again", 32'h1, 32'(rd[LSR_TOI]));
    peer_i.send(8'h79);
    rd_reg(OFF_LSR);
    chk("timeout new char", 32'h0, 32'(rd[LSR_TOI]));
    wr(OFF_FCR, 32'h0);
    wr(OFF_DATA, 32'h5a);
    chk("rts no fifo", 32'h3, 32'(REQ_TO_SEND_N));
    print_verdict;
  end
endmodule : tb_top
